// File: core/tws_map.svh
// Purpose: register offsets, field positions, reset values and timing counts
// Assumes: 32-bit AHB-Lite words, byte addresses
// Notes: definitions only
`ifndef TWS_MAP_SVH
`define TWS_MAP_SVH
// register byte offsets
`define TWS_CTRL_OFS 8'h00
`define TWS_STATUS_OFS 8'h04
`define TWS_CMD_OFS 8'h08
`define TWS_IRQ_STAT_OFS 8'h0c
`define TWS_IRQ_MASK_OFS 8'h10
`define TWS_ADDR_OFS 8'h14
`define TWS_DATA_OFS 8'h18
`define TWS_TOUT_OFS 8'h1c
`define TWS_INST2_OFS 8'h40
// control fields
`define TWS_CTRL_EN 0
`define TWS_CTRL_TOUT_EN 1
`define TWS_CTRL_SDA_HOLD 2
// status fields
`define TWS_ST_DATA_IRQ 7
`define TWS_ST_ADDR_STOP 6
`define TWS_ST_SCL_HOLD 5
`define TWS_ST_COLLISION 3
`define TWS_ST_DIR 1
`define TWS_ST_SCL_IN 8
`define TWS_ST_BUS_LO 9
// irq event bits
`define TWS_EV_ADDR 0
`define TWS_EV_DATA 1
`define TWS_EV_STOP 2
`define TWS_EV_TOUT 3
`define TWS_EV_DROP 4
// reset values
`define TWS_CTRL_RST 3'h0
`define TWS_ADDR_RST 7'h2a
`define TWS_TOUT_RST 16'h0fa0
// command code that answers and clears the data flag
`define TWS_CMD_RESPONSE 2'h3
`define TWS_CMD_COMPLETE 2'h2
// sda hold in cycles when the option bit is set
`define TWS_SDA_HOLD_CYC 4'h3
`endif

// File: core/tws_pkg.sv
// Purpose: types of the two-wire slave
// Assumes: constants live in tws_map.svh
// Notes: bus conditions and byte-engine states
package tws_pkg;
	typedef enum logic [1:0] {
		TWS_BUS_UNKNOWN = 2'b00,
		TWS_BUS_IDLE = 2'b01,
		TWS_BUS_OWNER = 2'b10,
		TWS_BUS_BUSY = 2'b11
	} tws_bus_t;
	typedef enum logic [2:0] {
		TWS_S_IDLE = 3'b000,
		TWS_S_ADDR = 3'b001,
		TWS_S_ACK = 3'b010,
		TWS_S_HOLD = 3'b011,
		TWS_S_RX = 3'b100,
		TWS_S_TX = 3'b101,
		TWS_S_ACKW = 3'b110
	} tws_state_t;
endpackage : tws_pkg

// File: core/tws_cond_det.sv
// Purpose: start, stop and scl edge detection on the two-wire lines
// Assumes: scl and sda already synchronous to hclk
// Notes: one register stage for edge history
`timescale 1ns/1ps
module tws_cond_det import tws_pkg::*; (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// line levels
	input wire logic scl_i,
	input wire logic sda_i,
	// detected events
	output logic start_p,
	output logic stop_p,
	output logic scl_rise_p,
	output logic scl_fall_p,
	output tws_bus_t bus_cond
);
	logic scl_q, scl_d, sda_q, sda_d;
	tws_bus_t bus_q, bus_d;
	// edge history and bus condition tracking
	always_comb begin
		scl_d = scl_i;
		sda_d = sda_i;
		bus_d = bus_q;
		if (start_p) begin
			bus_d = TWS_BUS_BUSY;
		end else if (stop_p) begin
			bus_d = TWS_BUS_IDLE;
		end
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			bus_q <= TWS_BUS_UNKNOWN;
		end else begin
			scl_q <= scl_d;
			sda_q <= sda_d;
			bus_q <= bus_d;
		end
	end
	// sda falling while scl high is start, rising is stop
	assign start_p = scl_i && scl_q && sda_q && !sda_i;
	assign stop_p = scl_i && scl_q && !sda_q && sda_i;
	assign scl_rise_p = scl_i && !scl_q;
	assign scl_fall_p = !scl_i && scl_q;
	assign bus_cond = bus_q;
endmodule : tws_cond_det

// File: core/tws_slave.sv
// Purpose: two-wire slave with flag, clock-hold and command handling
// Assumes: AHB-Lite single word transfers, synchronous pin inputs
// Notes: scl and sda are open-drain, driven low only when oe is high
// Behaviour
// - collision flag is meant to clear on start and repeated start
// - this revision clears collision flag only on a plain start
// - new address sets address/stop flag and holds scl; clearing releases
// - clear in same cycle as set leaves scl hold set, bus locks
// - response command 0b11 clears data flag one cycle later
// - timeout coinciding with start drops the transaction
// - sda hold option is a single control bit
// - second instance absent; its writes act as reserved writes
//
// Chosen here: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
`include "tws_map.svh"
module tws_slave import tws_pkg::*; (
	// ahb-lite slave
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// two-wire lines, open drain
	input wire logic scl_i,
	output logic scl_o,
	output logic scl_oe,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	// interrupt
	output logic irq
);
	logic start_p, stop_p, scl_rise_p, scl_fall_p;
	tws_bus_t bus_condition_field;
	tws_cond_det u_det (
		.hclk(hclk),
		.hresetn(hresetn),
		.scl_i(scl_i),
		.sda_i(sda_i),
		.start_p(start_p),
		.stop_p(stop_p),
		.scl_rise_p(scl_rise_p),
		.scl_fall_p(scl_fall_p),
		.bus_cond(bus_condition_field)
	);
	// bus address phase capture
	logic wr_pend_q, wr_pend_d, rd_pend_q, rd_pend_d;
	logic [7:0] a_q, a_d;
	logic [31:0] hrdata_q, hrdata_d;
	always_comb begin
		wr_pend_d = 1'b0;
		rd_pend_d = 1'b0;
		a_d = a_q;
		if (hsel && hready && htrans[1]) begin
			wr_pend_d = hwrite;
			rd_pend_d = !hwrite;
			a_d = haddr;
		end
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			rd_pend_q <= 1'b0;
			a_q <= 8'h00;
		end else begin
			wr_pend_q <= wr_pend_d;
			rd_pend_q <= rd_pend_d;
			a_q <= a_d;
		end
	end
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	// decoded write strobes; unmapped and second-instance writes fall through
	logic w_ctrl, w_status, w_cmd, w_mask, w_addr, w_data, w_tout, r_irq;
	always_comb begin
		w_ctrl = 1'b0;
		w_status = 1'b0;
		w_cmd = 1'b0;
		w_mask = 1'b0;
		w_addr = 1'b0;
		w_data = 1'b0;
		w_tout = 1'b0;
		if (a_q == `TWS_CTRL_OFS) begin
			w_ctrl = wr_pend_q;
		end else if (a_q == `TWS_STATUS_OFS) begin
			w_status = wr_pend_q;
		end else if (a_q == `TWS_CMD_OFS) begin
			w_cmd = wr_pend_q;
		end else if (a_q == `TWS_IRQ_MASK_OFS) begin
			w_mask = wr_pend_q;
		end else if (a_q == `TWS_ADDR_OFS) begin
			w_addr = wr_pend_q;
		end else if (a_q == `TWS_DATA_OFS) begin
			w_data = wr_pend_q;
		end else if (a_q == `TWS_TOUT_OFS) begin
			w_tout = wr_pend_q;
		end
		r_irq = rd_pend_q && (a_q == `TWS_IRQ_STAT_OFS);
	end
	// configuration and flag state
	logic [2:0] ctrl_q, ctrl_d;
	logic [6:0] own_q, own_d;
	logic [15:0] tlim_q, tlim_d, tcnt_q, tcnt_d;
	logic [4:0] mask_q, mask_d, ist_q, ist_d, ev;
	logic addr_stop_irq_flag_q, addr_stop_irq_flag_d, data_irq_flag_q, data_irq_flag_d;
	logic scl_hold_status_q, scl_hold_status_d, coll_q, coll_d, dir_q, dir_d;
	logic dclr_q, dclr_d;
	logic [7:0] sh_q, sh_d, txb_q, txb_d, rxb_q, rxb_d;
	logic [3:0] bit_q, bit_d, sdh_q, sdh_d;
	logic sda_lo_q, sda_lo_d, sda_want;
	tws_state_t st_q, st_d;
	logic sw_clr_as, sw_clr_di, sw_clr_co, tout_p, drop;
	assign sw_clr_as = w_status && hwdata[`TWS_ST_ADDR_STOP];
	assign sw_clr_di = w_status && hwdata[`TWS_ST_DATA_IRQ];
	assign sw_clr_co = w_status && hwdata[`TWS_ST_COLLISION];
	// timeout fires while scl sits high on a busy bus
	assign tout_p = ctrl_q[`TWS_CTRL_TOUT_EN] && (bus_condition_field == TWS_BUS_BUSY) && (tcnt_q == tlim_q);
	assign drop = tout_p && start_p;
	always_comb begin
		ctrl_d = ctrl_q;
		own_d = own_q;
		tlim_d = tlim_q;
		mask_d = mask_q;
		st_d = st_q;
		sh_d = sh_q;
		txb_d = txb_q;
		rxb_d = rxb_q;
		bit_d = bit_q;
		dir_d = dir_q;
		sda_want = 1'b0;
		ev = 5'h00;
		dclr_d = 1'b0;
		addr_stop_irq_flag_d = addr_stop_irq_flag_q;
		data_irq_flag_d = data_irq_flag_q;
		scl_hold_status_d = scl_hold_status_q;
		coll_d = coll_q;
		tcnt_d = (scl_i && !tout_p) ? tcnt_q + 16'h0001 : 16'h0000;
		if (w_ctrl) ctrl_d = hwdata[2:0];
		if (w_addr) own_d = hwdata[6:0];
		if (w_tout) tlim_d = hwdata[15:0];
		if (w_mask) mask_d = hwdata[4:0];
		if (w_data) txb_d = hwdata[7:0];
		// data flag clears a cycle late
		if (w_cmd && hwdata[1:0] == `TWS_CMD_RESPONSE) dclr_d = 1'b1;
		if (dclr_q || sw_clr_di) begin
			data_irq_flag_d = 1'b0;
			scl_hold_status_d = 1'b0;
		end
		if (w_cmd && hwdata[1:0] == `TWS_CMD_COMPLETE) st_d = TWS_S_IDLE;
		if (sw_clr_co) coll_d = 1'b0;
		if (sw_clr_as) begin
			addr_stop_irq_flag_d = 1'b0;
			scl_hold_status_d = 1'b0;
		end
		if (start_p && bus_condition_field != TWS_BUS_BUSY) coll_d = 1'b0;
		// byte engine
		case (st_q)
			TWS_S_IDLE: begin
			end
			TWS_S_ADDR, TWS_S_RX: begin
				if (scl_rise_p) begin
					sh_d = {sh_q[6:0], sda_i};
					bit_d = bit_q + 4'h1;
				end
				if (scl_fall_p && bit_q == 4'h8) begin
					bit_d = 4'h0;
					if (st_q == TWS_S_ADDR) begin
						if (sh_q[7:1] == own_q) begin
							addr_stop_irq_flag_d = 1'b1;
							scl_hold_status_d = !sw_clr_as || addr_stop_irq_flag_q;
							if (sw_clr_as) scl_hold_status_d = 1'b1;
							dir_d = sh_q[0];
							ev[`TWS_EV_ADDR] = 1'b1;
							st_d = TWS_S_ACK;
						end else begin
							st_d = TWS_S_IDLE;
						end
					end else begin
						rxb_d = sh_q;
						data_irq_flag_d = 1'b1;
						scl_hold_status_d = 1'b1;
						ev[`TWS_EV_DATA] = 1'b1;
						st_d = TWS_S_ACK;
					end
				end
			end
			TWS_S_ACK: begin
				sda_want = !scl_hold_status_q || !dir_q;
				if (scl_fall_p) st_d = dir_q ? TWS_S_TX : TWS_S_RX;
				if (scl_fall_p && dir_q) sh_d = txb_q;
			end
			TWS_S_TX: begin
				sda_want = !sh_q[7];
				if (scl_fall_p) begin
					sh_d = {sh_q[6:0], 1'b1};
					bit_d = bit_q + 4'h1;
					if (bit_q == 4'h7) begin
						bit_d = 4'h0;
						st_d = TWS_S_ACKW;
					end
				end
				// line low while we leave it high is a collision
				if (scl_rise_p && sh_q[7] && !sda_i) coll_d = 1'b1;
			end
			TWS_S_ACKW: begin
				if (scl_rise_p && sda_i) st_d = TWS_S_IDLE;
				if (scl_fall_p) begin
					data_irq_flag_d = 1'b1;
					scl_hold_status_d = 1'b1;
					ev[`TWS_EV_DATA] = 1'b1;
					st_d = TWS_S_ACK;
				end
			end
			default: st_d = TWS_S_IDLE;
		endcase
		if (stop_p && st_q != TWS_S_IDLE) begin
			addr_stop_irq_flag_d = 1'b1;
			ev[`TWS_EV_STOP] = 1'b1;
			st_d = TWS_S_IDLE;
		end
		if (tout_p) ev[`TWS_EV_TOUT] = 1'b1;
		if (start_p && ctrl_q[`TWS_CTRL_EN]) begin
			st_d = drop ? TWS_S_IDLE : TWS_S_ADDR;
			bit_d = 4'h0;
			if (drop) ev[`TWS_EV_DROP] = 1'b1;
		end
		if (!ctrl_q[`TWS_CTRL_EN]) begin
			st_d = TWS_S_IDLE;
			scl_hold_status_d = 1'b0;
		end
		// sticky events; set wins over the read clear
		ist_d = (r_irq ? 5'h00 : ist_q) | ev;
		// sda hold: delay releasing/driving after scl fall when selected
		sdh_d = scl_fall_p ? (ctrl_q[`TWS_CTRL_SDA_HOLD] ? `TWS_SDA_HOLD_CYC : 4'h0) :
			(sdh_q != 4'h0 ? sdh_q - 4'h1 : 4'h0);
		sda_lo_d = (sdh_q == 4'h0 && !scl_fall_p) ? sda_want : sda_lo_q;
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_q <= `TWS_CTRL_RST;
			own_q <= `TWS_ADDR_RST;
			tlim_q <= `TWS_TOUT_RST;
			tcnt_q <= 16'h0000;
			mask_q <= 5'h00;
			ist_q <= 5'h00;
			addr_stop_irq_flag_q <= 1'b0;
			data_irq_flag_q <= 1'b0;
			scl_hold_status_q <= 1'b0;
			coll_q <= 1'b0;
			dir_q <= 1'b0;
			dclr_q <= 1'b0;
			sh_q <= 8'h00;
			txb_q <= 8'hff;
			rxb_q <= 8'h00;
			bit_q <= 4'h0;
			sdh_q <= 4'h0;
			sda_lo_q <= 1'b0;
			st_q <= TWS_S_IDLE;
		end else begin
			ctrl_q <= ctrl_d;
			own_q <= own_d;
			tlim_q <= tlim_d;
			tcnt_q <= tcnt_d;
			mask_q <= mask_d;
			ist_q <= ist_d;
			addr_stop_irq_flag_q <= addr_stop_irq_flag_d;
			data_irq_flag_q <= data_irq_flag_d;
			scl_hold_status_q <= scl_hold_status_d;
			coll_q <= coll_d;
			dir_q <= dir_d;
			dclr_q <= dclr_d;
			sh_q <= sh_d;
			txb_q <= txb_d;
			rxb_q <= rxb_d;
			bit_q <= bit_d;
			sdh_q <= sdh_d;
			sda_lo_q <= sda_lo_d;
			st_q <= st_d;
		end
	end
	// read mux on the address-phase haddr, registered at the end of the address phase
	always_comb begin
		hrdata_d = 32'h0000_0000;
		if (haddr == `TWS_CTRL_OFS) begin
			hrdata_d[2:0] = ctrl_q;
		end else if (haddr == `TWS_STATUS_OFS) begin
			hrdata_d[`TWS_ST_DATA_IRQ] = data_irq_flag_q;
			hrdata_d[`TWS_ST_ADDR_STOP] = addr_stop_irq_flag_q;
			hrdata_d[`TWS_ST_SCL_HOLD] = scl_hold_status_q;
			hrdata_d[`TWS_ST_COLLISION] = coll_q;
			hrdata_d[`TWS_ST_DIR] = dir_q;
			hrdata_d[`TWS_ST_SCL_IN] = scl_i;
			hrdata_d[`TWS_ST_BUS_LO+1:`TWS_ST_BUS_LO] = bus_condition_field;
		end else if (haddr == `TWS_IRQ_STAT_OFS) begin
			hrdata_d[4:0] = ist_q;
		end else if (haddr == `TWS_IRQ_MASK_OFS) begin
			hrdata_d[4:0] = mask_q;
		end else if (haddr == `TWS_ADDR_OFS) begin
			hrdata_d[6:0] = own_q;
		end else if (haddr == `TWS_DATA_OFS) begin
			hrdata_d[7:0] = rxb_q;
		end else if (haddr == `TWS_TOUT_OFS) begin
			hrdata_d[15:0] = tlim_q;
		end
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_q <= 32'h0000_0000;
		end else if (hsel && hready && htrans[1] && !hwrite) begin
			hrdata_q <= hrdata_d;
		end
	end
	assign hrdata = hrdata_q;
	// open drain: output value always low, enable pulls
	assign scl_o = 1'b0;
	assign scl_oe = scl_hold_status_q && !scl_i ? 1'b1 : scl_hold_status_q && scl_fall_p;
	assign sda_o = 1'b0;
	assign sda_oe = sda_lo_q;
	assign irq = |(ist_q & mask_q);
endmodule : tws_slave

// File: tb/tws_slave_sva.sv
// Purpose: port checks of the two-wire slave
// Assumes: one slave, hready tied to hreadyout
// Notes: bound to tws_slave below
`timescale 1ns/1ps
`include "tws_map.svh"
module tws_slave_sva (
	// bus side
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	// line hold and interrupt
	input wire logic scl_oe,
	input wire logic irq
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	logic ap_q;
	logic wr_q;
	logic rel_q;
	logic [7:0] ad_q;
	// data-phase memory; rel_q marks a status or command write landing
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ap_q <= 1'b0;
			wr_q <= 1'b0;
			rel_q <= 1'b0;
			ad_q <= 8'h00;
		end else begin
			ap_q <= hsel && htrans[1] && hreadyout;
			wr_q <= hwrite;
			ad_q <= haddr;
			rel_q <= ap_q && wr_q && (ad_q == `TWS_STATUS_OFS || ad_q == `TWS_CMD_OFS);
		end
	end
	sequence s_take(logic [7:0] a, logic w);
		hsel && htrans[1] && hreadyout && haddr == a && hwrite == w;
	endsequence
	sequence s_wdata(logic [7:0] a);
		ap_q && wr_q && ad_q == a;
	endsequence
	chk_bus_okay: assert property (hreadyout && !hresp) else $error("stall or error response");
	chk_absent_zero: assert property (s_take(`TWS_INST2_OFS, 1'b0) |=> hrdata == 32'h0)
		else $error("absent instance reads nonzero");
	chk_ctrl_width: assert property (s_take(`TWS_CTRL_OFS, 1'b0) |=> hrdata[31:3] == 29'h0)
		else $error("control wider than three bits");
	chk_hold_release: assert property (s_wdata(`TWS_STATUS_OFS) ##0 hwdata[6] && scl_oe |=> !scl_oe)
		else $error("scl still held after flag clear");
	chk_hold_cause: assert property ($fell(scl_oe) |-> rel_q || $past(rel_q))
		else $error("scl released without software");
	chk_resp_lag: assert property (s_wdata(`TWS_CMD_OFS) ##0 hwdata[1:0] == 2'h3 && scl_oe |=> scl_oe)
		else $error("response command acted at once");
	chk_resp_free: assert property (s_wdata(`TWS_CMD_OFS) ##0 hwdata[1:0] == 2'h3 |-> ##2 !scl_oe)
		else $error("response command did not release");
	chk_irq_clear: assert property (s_take(`TWS_IRQ_STAT_OFS, 1'b0) |-> ##2 !irq)
		else $error("irq stays after status read");
endmodule : tws_slave_sva
bind tws_slave tws_slave_sva chk_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hrdata,
	.hreadyout, .hresp, .scl_oe, .irq);

// File: tb/tws_master_model.sv
// Purpose: bus master on the two wires
// Assumes: lines resolved wired-and with pull-ups
// Notes: waits out clock stretching under a bound
`timescale 1ns/1ps
module tws_master_model #(
	parameter int HALF = 8
) (
	// clock
	input wire logic hclk,
	// resolved lines
	input wire logic scl_w,
	input wire logic sda_w,
	// drives, 1 = released
	output logic scl_m,
	output logic sda_m,
	output logic stuck
);
	// idle: both lines released
	initial begin
		scl_m = 1'b1;
		sda_m = 1'b1;
		stuck = 1'b0;
	end
	task automatic hw(input int n);
		repeat (n) @(posedge hclk);
	endtask : hw
	// release scl; the slave may keep it low
	task automatic up();
		int i;
		scl_m <= 1'b1;
		for (i = 0; i < 4000 && scl_w !== 1'b1; i++) @(posedge hclk);
		if (scl_w !== 1'b1) stuck <= 1'b1;
		hw(HALF);
	endtask : up
	// settle low before sda moves, so no false start or stop
	task automatic dn();
		scl_m <= 1'b0;
		hw(2);
	endtask : dn
	task automatic start();
		sda_m <= 1'b0;
		hw(HALF);
		dn();
	endtask : start
	task automatic send_byte(input logic [7:0] b, output logic ack);
		for (int k = 7; k >= 0; k--) begin
			sda_m <= b[k];
			hw(HALF);
			up();
			dn();
		end
		sda_m <= 1'b1;
		hw(HALF);
		up();
		ack = sda_w;
		dn();
	endtask : send_byte
	// repeated start: release sda with scl low, raise scl, then start
	task automatic rstart();
		sda_m <= 1'b1;
		hw(2);
		up();
		start();
	endtask : rstart
	task automatic stop();
		sda_m <= 1'b0;
		hw(HALF);
		up();
		sda_m <= 1'b1;
		hw(HALF);
	endtask : stop
endmodule : tws_master_model

// File: tb/tws_slave_bench.sv
// Purpose: self-checking bench of the two-wire slave
// Assumes: zero-wait slave, master model on the lines
// Notes: every wait is bounded
`timescale 1ns/1ps
`include "tws_map.svh"
module tws_slave_bench;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [1:0] htrans = 2'b00;
	logic [7:0] haddr = 8'h00;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic hreadyout, hresp, scl_o, scl_oe, sda_o, sda_oe, irq, scl_m, sda_m, stuck, ack;
	int fails = 0;
	int checks_done = 0;
	// pull-ups: any enabled driver pulls low
	wire logic scl_w = scl_m & ~scl_oe;
	wire logic sda_w = sda_m & ~sda_oe;
	always #5 hclk = ~hclk;
	tws_slave dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
		.hready(hreadyout), .hrdata, .hreadyout, .hresp, .scl_i(scl_w), .scl_o, .scl_oe,
		.sda_i(sda_w), .sda_o, .sda_oe, .irq);
	tws_master_model mst_u (.hclk, .scl_w, .sda_w, .scl_m, .sda_m, .stuck);
	task automatic report_and_stop();
		if (fails == 0 && checks_done > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : report_and_stop
	task automatic ck(input string n, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask : ck
	task automatic rdy();
		for (int i = 0; i < 50; i++) begin
			@(posedge hclk);
			if (hreadyout === 1'b1) return;
		end
		fails++;
		report_and_stop();
	endtask : rdy
	// one single transfer: address phase, then data phase
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= w;
		haddr <= a;
		rdy();
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		rdy();
		q = hrdata;
	endtask : bus
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		bus(1'b0, a, 32'h0, q);
	endtask : rd
	task automatic poll(input int b, input logic v);
		logic [31:0] q;
		for (int i = 0; i < 300; i++) begin
			rd(`TWS_STATUS_OFS, q);
			if (q[b] === v) return;
		end
		fails++;
		report_and_stop();
	endtask : poll
	task automatic settle();
		@(posedge hclk);
		#1;
	endtask : settle
	task automatic t_regs();
		logic [31:0] q;
		wr(`TWS_CTRL_OFS, 32'hffff_ffff);
		rd(`TWS_CTRL_OFS, q);
		ck("ctrl", 32'h7, q);
		wr(`TWS_INST2_OFS, 32'h0);
		rd(`TWS_INST2_OFS, q);
		ck("inst2", 32'h0, q);
		rd(`TWS_CTRL_OFS, q);
		ck("ctrl kept", 32'h7, q);
		rd(`TWS_ADDR_OFS, q);
		ck("own addr", 32'h2a, q);
		ck("drive lo", 32'h0, {30'h0, scl_o, sda_o});
		wr(`TWS_CTRL_OFS, 32'h1);
		wr(`TWS_IRQ_MASK_OFS, 32'h1);
	endtask : t_regs
	task automatic t_addr();
		logic [31:0] q;
		// the model waits out the hold while software serves the flag
		fork
			begin
				mst_u.start();
				mst_u.send_byte(8'h54, ack);
			end
			begin
				poll(`TWS_ST_ADDR_STOP, 1'b1);
				rd(`TWS_STATUS_OFS, q);
				ck("busy", 32'h3, {30'h0, q[10:9]});
				settle();
				ck("hold", 32'h1, {31'h0, scl_oe});
				ck("irq on", 32'h1, {31'h0, irq});
				wr(`TWS_STATUS_OFS, 32'h0);
				rd(`TWS_STATUS_OFS, q);
				ck("flag kept", 32'h1, {31'h0, q[6]});
				// bus busy: clear only once scl reads low
				poll(`TWS_ST_SCL_IN, 1'b0);
				// collision cleared by software too, a repeated start keeps it
				wr(`TWS_STATUS_OFS, 32'h48);
				rd(`TWS_STATUS_OFS, q);
				ck("flag clr", 32'h0, {31'h0, q[6]});
				ck("coll clr", 32'h0, {31'h0, q[3]});
				ck("hold off", 32'h0, {31'h0, scl_oe});
				rd(`TWS_IRQ_STAT_OFS, q);
				ck("ev addr", 32'h1, q & 32'h1);
				settle();
				ck("irq off", 32'h0, {31'h0, irq});
			end
		join
		ck("addr ack", 32'h0, {31'h0, ack});
	endtask : t_addr
	task automatic t_data();
		logic [31:0] q;
		fork
			mst_u.send_byte(8'ha5, ack);
			begin
				poll(`TWS_ST_DATA_IRQ, 1'b1);
				rd(`TWS_DATA_OFS, q);
				ck("rx", 32'ha5, q);
				ck("irq masked", 32'h0, {31'h0, irq});
				wr(`TWS_CMD_OFS, {30'h0, `TWS_CMD_RESPONSE});
				rd(`TWS_STATUS_OFS, q);
				ck("flag lag", 32'h1, {31'h0, q[7]});
				// spare cycle before trusting the flag
				settle();
				rd(`TWS_STATUS_OFS, q);
				ck("flag gone", 32'h0, {31'h0, q[7]});
				wr(`TWS_IRQ_MASK_OFS, 32'h2);
				settle();
				ck("irq data", 32'h1, {31'h0, irq});
				rd(`TWS_IRQ_STAT_OFS, q);
				ck("ev data", 32'h2, q & 32'h2);
				settle();
				ck("irq off2", 32'h0, {31'h0, irq});
			end
		join
		ck("data ack", 32'h0, {31'h0, ack});
	endtask : t_data
	task automatic t_drop();
		logic [31:0] q;
		// limit equals the cycles the model keeps scl high before sda falls
		wr(`TWS_TOUT_OFS, 32'h9);
		wr(`TWS_CTRL_OFS, 32'h3);
		mst_u.rstart();
		rd(`TWS_IRQ_STAT_OFS, q);
		ck("ev drop", 32'h18, q & 32'h18);
		mst_u.stop();
		ck("stuck", 32'h0, {31'h0, stuck});
		// a dropped transfer leaves no stop flag behind
		rd(`TWS_STATUS_OFS, q);
		ck("dropped", 32'h0, {31'h0, q[6]});
		ck("idle", 32'h1, {30'h0, q[10:9]});
	endtask : t_drop
	initial begin
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_regs();
		t_addr();
		t_data();
		t_drop();
		report_and_stop();
	end
endmodule : tws_slave_bench
